// *** verilog/sar_adc_control_sequencer.sv ***
// Converter control registers, AXI4-Lite slave and conversion sequencer.
//
// Register access over AXI4-Lite and the address map were left to the implementer.
module sar_adc_control_sequencer #(
	parameter logic [15:0] IMPL_CHANNELS = 16'h07ff
) (
	input  logic        aclk,
	input  logic        aresetn,
	input  logic [7:0]  awaddr,
	input  logic        awvalid,
	output logic        awready,
	input  logic [31:0] wdata,
	input  logic [3:0]  wstrb,
	input  logic        wvalid,
	output logic        wready,
	output logic [1:0]  bresp,
	output logic        bvalid,
	input  logic        bready,
	input  logic [7:0]  araddr,
	input  logic        arvalid,
	output logic        arready,
	output logic [31:0] rdata,
	output logic [1:0]  rresp,
	output logic        rvalid,
	input  logic        rready,
	input  logic        portb_analog_default,
	input  logic        comparator_high,
	input  logic        rc_clock_tick,
	input  logic        device_sleep,
	output logic [3:0]  analog_channel,
	output logic        neg_ref_external,
	output logic        pos_ref_external,
	output logic [10:0] pin_analog,
	output logic        sample_enable,
	output logic [9:0]  sar_trial,
	output logic        conversion_done_flag,
	output logic        converter_enabled
);
	localparam int NI = sar_adc_pkg::NUM_INPUTS;

	logic [3:0]            chan_r;
	logic                  on_r;
	logic                  go_r;
	logic                  nref_r;
	logic                  pref_r;
	logic [3:0]            pcfg_r;
	logic                  just_r;
	logic [2:0]            acqt_r;
	logic [2:0]            adcs_r;
	logic                  flag_r;
	logic [7:0]            res_hi_r;
	logic [7:0]            res_lo_r;
	sar_adc_pkg::state_t   state_r;
	sar_adc_pkg::state_t   state_nxt;
	logic [4:0]            cnt_r;
	logic [6:0]            div_r;
	logic [9:0]            sar_r;
	logic [9:0]            bit_r;
	logic                  sample_r;
	logic [NI-1:0]         pin_r;

	logic                  aw_have_r;
	logic                  w_have_r;
	logic                  awready_r;
	logic                  wready_r;
	logic                  bvalid_r;
	logic [1:0]            bresp_r;
	logic [5:0]            widx_r;
	logic [7:0]            wbyte_r;
	logic                  wlane_r;
	logic                  arready_r;
	logic                  rvalid_r;
	logic [1:0]            rresp_r;
	logic [31:0]           rdata_r;

	logic                  aw_take;
	logic                  w_take;
	logic                  wr_do;
	logic                  aw_have_nxt;
	logic                  w_have_nxt;
	logic                  rd_take;
	logic                  rvalid_nxt;
	logic                  wr_ok;
	logic                  wr0;
	logic                  wr1;
	logic                  wr2;
	logic                  wr_st;
	logic [31:0]           rd_word;
	logic                  rd_err;
	logic                  rc_sel;
	logic                  tick;
	logic                  run_ok;
	logic                  complete;
	logic [9:0]            sar_final;
	logic [9:0]            result;
	logic [3:0]            ndig;
	logic [2:0]            first_state;

	assign awready              = awready_r;
	assign wready               = wready_r;
	assign bvalid               = bvalid_r;
	assign bresp                = bresp_r;
	assign arready              = arready_r;
	assign rvalid               = rvalid_r;
	assign rresp                = rresp_r;
	assign rdata                = rdata_r;
	assign analog_channel       = chan_r;
	assign neg_ref_external     = nref_r;
	assign pos_ref_external     = pref_r;
	assign pin_analog           = pin_r;
	assign sample_enable        = sample_r;
	assign sar_trial            = sar_r;
	assign conversion_done_flag = flag_r;
	assign converter_enabled    = on_r;

	// Write address and data are held independently; either may come first.
	assign aw_take     = awvalid & awready_r;
	assign w_take      = wvalid & wready_r;
	assign wr_do       = aw_have_r & w_have_r & ~bvalid_r;
	assign aw_have_nxt = (aw_have_r | aw_take) & ~wr_do;
	assign w_have_nxt  = (w_have_r | w_take) & ~wr_do;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			w_have_r  <= 1'b0;
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
		end else begin
			aw_have_r <= aw_have_nxt;
			w_have_r  <= w_have_nxt;
			awready_r <= ~aw_have_nxt;
			wready_r  <= ~w_have_nxt;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			widx_r  <= 6'h00;
			wbyte_r <= 8'h00;
			wlane_r <= 1'b0;
		end else begin
			if (aw_take)
				widx_r <= awaddr[7:2];
			if (w_take) begin
				wbyte_r <= wdata[7:0];
				wlane_r <= wstrb[0];
			end
		end
	end

	assign wr_ok = wr_do & wlane_r;
	assign wr0   = wr_ok & (widx_r == sar_adc_pkg::WIX_CTRL0);
	assign wr1   = wr_ok & (widx_r == sar_adc_pkg::WIX_CTRL1);
	assign wr2   = wr_ok & (widx_r == sar_adc_pkg::WIX_CTRL2);
	assign wr_st = wr_ok & (widx_r == sar_adc_pkg::WIX_STATUS);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= sar_adc_pkg::RESP_OKAY;
		end else if (wr_do) begin
			bvalid_r <= 1'b1;
			bresp_r  <= (widx_r > sar_adc_pkg::WIX_STATUS) ?
				sar_adc_pkg::RESP_SLVERR : sar_adc_pkg::RESP_OKAY;
		end else if (bready) begin
			bvalid_r <= 1'b0;
		end
	end

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_err  = 1'b0;
		case (araddr[7:2])
			sar_adc_pkg::WIX_CTRL0:  rd_word[7:0] = {2'b00, chan_r, go_r, on_r};
			sar_adc_pkg::WIX_CTRL1:  rd_word[7:0] = {2'b00, nref_r, pref_r, pcfg_r};
			sar_adc_pkg::WIX_CTRL2:  rd_word[7:0] = {just_r, 1'b0, acqt_r, adcs_r};
			sar_adc_pkg::WIX_RES_HI: rd_word[7:0] = res_hi_r;
			sar_adc_pkg::WIX_RES_LO: rd_word[7:0] = res_lo_r;
			sar_adc_pkg::WIX_STATUS: rd_word[7:0] = {7'h00, flag_r};
			default:                 rd_err = 1'b1;
		endcase
	end

	assign rd_take    = arvalid & arready_r;
	assign rvalid_nxt = rd_take | (rvalid_r & ~rready);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rresp_r   <= sar_adc_pkg::RESP_OKAY;
			rdata_r   <= 32'h0000_0000;
		end else begin
			arready_r <= ~rvalid_nxt;
			rvalid_r  <= rvalid_nxt;
			if (rd_take) begin
				rdata_r <= rd_word;
				rresp_r <= rd_err ? sar_adc_pkg::RESP_SLVERR :
					sar_adc_pkg::RESP_OKAY;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chan_r <= 4'h0;
			on_r   <= 1'b0;
			nref_r <= 1'b0;
			pref_r <= 1'b0;
			just_r <= 1'b0;
			acqt_r <= 3'h0;
			adcs_r <= 3'h0;
			pcfg_r <= portb_analog_default ? sar_adc_pkg::PCFG_ALL_ANALOG :
				sar_adc_pkg::PCFG_PORTB_DIG;
		end else begin
			if (wr0) begin
				chan_r <= wbyte_r[sar_adc_pkg::CTRL0_CHS_LSB +: 4];
				on_r   <= wbyte_r[sar_adc_pkg::CTRL0_ON];
			end
			if (wr1) begin
				nref_r <= wbyte_r[sar_adc_pkg::CTRL1_NREF];
				pref_r <= wbyte_r[sar_adc_pkg::CTRL1_PREF];
				pcfg_r <= wbyte_r[sar_adc_pkg::CTRL1_PCF_LSB +: 4];
			end
			if (wr2) begin
				just_r <= wbyte_r[sar_adc_pkg::CTRL2_JUST];
				acqt_r <= wbyte_r[sar_adc_pkg::CTRL2_ACQ_LSB +: 3];
				adcs_r <= wbyte_r[sar_adc_pkg::CTRL2_CLK_LSB +: 3];
			end
		end
	end

	// Clearing the start bit by software while busy abandons the conversion.
	// Start/done bit.
	always_ff @(posedge aclk) begin
		if (!aresetn)
			go_r <= 1'b0;
		else if (!on_r || complete)
			go_r <= 1'b0;
		else if (wr0)
			go_r <= wbyte_r[sar_adc_pkg::CTRL0_GO] &
				wbyte_r[sar_adc_pkg::CTRL0_ON];
	end

	assign rc_sel = sar_adc_pkg::is_rc(adcs_r);

	// The oscillator stops in sleep, so only the RC source keeps ticking.
	// Sleep stalls osc.
	always_comb begin
		if (device_sleep && !rc_sel)
			tick = 1'b0;
		else if (rc_sel)
			tick = rc_clock_tick;
		else
			tick = (div_r == sar_adc_pkg::clock_divide(adcs_r) - 7'h01);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			div_r <= 7'h00;
		else if (state_r == sar_adc_pkg::ST_IDLE ||
			state_r == sar_adc_pkg::ST_DELAY || tick)
			div_r <= 7'h00;
		else if (!device_sleep)
			div_r <= div_r + 7'h01;
	end

	assign run_ok = on_r & go_r;

	assign complete = (state_r == sar_adc_pkg::ST_CONV) && tick && run_ok &&
		(cnt_r == sar_adc_pkg::CONV_PERIODS - 5'h01);

	assign first_state = (acqt_r != 3'h0) ? 3'h2 : 3'h3;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			sar_adc_pkg::ST_IDLE: begin
				if (run_ok && rc_sel)
					state_nxt = sar_adc_pkg::ST_DELAY;
				else if (run_ok && first_state == 3'h2)
					state_nxt = sar_adc_pkg::ST_ACQ;
				else if (run_ok)
					state_nxt = sar_adc_pkg::ST_CONV;
			end
			sar_adc_pkg::ST_DELAY: begin
				if (!run_ok)
					state_nxt = sar_adc_pkg::ST_IDLE;
				else if (cnt_r == sar_adc_pkg::INSTR_CYCLE_OSC - 5'h01)
					state_nxt = (first_state == 3'h2) ?
						sar_adc_pkg::ST_ACQ : sar_adc_pkg::ST_CONV;
			end
			sar_adc_pkg::ST_ACQ: begin
				if (!run_ok)
					state_nxt = sar_adc_pkg::ST_IDLE;
				else if (tick && cnt_r ==
					sar_adc_pkg::acq_periods(acqt_r) - 5'h01)
					state_nxt = sar_adc_pkg::ST_CONV;
			end
			sar_adc_pkg::ST_CONV: begin
				if (!run_ok)
					state_nxt = sar_adc_pkg::ST_IDLE;
				else if (complete)
					state_nxt = sar_adc_pkg::ST_RECOVER;
			end
			sar_adc_pkg::ST_RECOVER: begin
				if (!on_r)
					state_nxt = sar_adc_pkg::ST_IDLE;
				else if (tick && cnt_r ==
					sar_adc_pkg::RECOVER_PERIODS - 5'h01)
					state_nxt = sar_adc_pkg::ST_IDLE;
			end
			default: state_nxt = sar_adc_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			state_r <= sar_adc_pkg::ST_IDLE;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			cnt_r <= 5'h00;
		else if (state_nxt != state_r)
			cnt_r <= 5'h00;
		else if (state_r == sar_adc_pkg::ST_DELAY || tick)
			cnt_r <= cnt_r + 5'h01;
	end

	// The first conversion period only isolates the hold capacitor.
	// Successive approximation.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sar_r <= 10'h000;
			bit_r <= 10'h000;
		end else if (state_nxt == sar_adc_pkg::ST_CONV &&
			state_r != sar_adc_pkg::ST_CONV) begin
			sar_r <= sar_adc_pkg::SAR_MSB;
			bit_r <= sar_adc_pkg::SAR_MSB;
		end else if (state_r == sar_adc_pkg::ST_CONV && tick &&
			cnt_r != 5'h00) begin
			sar_r <= sar_final | (bit_r >> 1);
			bit_r <= bit_r >> 1;
		end
	end

	assign sar_final = comparator_high ? sar_r : (sar_r & ~bit_r);
	assign result = IMPL_CHANNELS[chan_r] ? sar_final :
		sar_adc_pkg::FULL_SCALE;

	// No reset here: the result survives a reset untouched.
	// Result kept.
	always_ff @(posedge aclk) begin
		if (complete) begin
			if (just_r) begin
				res_hi_r <= {6'h00, result[9:8]};
				res_lo_r <= result[7:0];
			end else begin
				res_hi_r <= result[9:2];
				res_lo_r <= {result[1:0], 6'h00};
			end
		end
	end

	// A completion in the same cycle as a clear wins.
	// Set done flag.
	always_ff @(posedge aclk) begin
		if (!aresetn)
			flag_r <= 1'b0;
		else if (complete)
			flag_r <= 1'b1;
		else if (wr_st && wbyte_r[sar_adc_pkg::STATUS_DONE])
			flag_r <= 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			sample_r <= 1'b0;
		else
			sample_r <= on_r & (state_nxt == sar_adc_pkg::ST_IDLE ||
				state_nxt == sar_adc_pkg::ST_ACQ);
	end

	assign ndig = (pcfg_r > sar_adc_pkg::PCFG_OFFSET) ?
		pcfg_r - sar_adc_pkg::PCFG_OFFSET : 4'h0;

	for (genvar i = 0; i < NI; i++) begin : g_pin
		always_ff @(posedge aclk) begin
			if (!aresetn)
				pin_r[i] <= 1'b0;
			else
				pin_r[i] <= (4'(i) < 4'(NI) - ndig);
		end
	end
endmodule : sar_adc_control_sequencer

// *** verilog/sar_adc_pkg.sv ***
// Shared constants, types and tables for the SAR converter sequencer.
package sar_adc_pkg;
	// Word indices; the byte address is four times the index.
	localparam logic [5:0] WIX_CTRL0   = 6'h00;
	localparam logic [5:0] WIX_CTRL1   = 6'h01;
	localparam logic [5:0] WIX_CTRL2   = 6'h02;
	localparam logic [5:0] WIX_RES_HI  = 6'h03;
	localparam logic [5:0] WIX_RES_LO  = 6'h04;
	localparam logic [5:0] WIX_STATUS  = 6'h05;
	localparam int CTRL0_ON      = 0;
	localparam int CTRL0_GO      = 1;
	localparam int CTRL0_CHS_LSB = 2;
	localparam int CTRL1_PCF_LSB = 0;
	localparam int CTRL1_PREF    = 4;
	localparam int CTRL1_NREF    = 5;
	localparam int CTRL2_CLK_LSB = 0;
	localparam int CTRL2_ACQ_LSB = 3;
	localparam int CTRL2_JUST    = 7;
	localparam int STATUS_DONE   = 0;
	localparam logic [3:0] PCFG_ALL_ANALOG = 4'h0;
	localparam logic [3:0] PCFG_PORTB_DIG  = 4'h7;
	localparam logic [3:0] PCFG_OFFSET     = 4'h4;
	localparam int         NUM_INPUTS      = 11;
	localparam logic [9:0] FULL_SCALE      = 10'h3ff;
	localparam logic [9:0] SAR_MSB         = 10'h200;
	localparam logic [4:0] CONV_PERIODS    = 5'h0b;
	localparam logic [4:0] RECOVER_PERIODS = 5'h02;
	localparam logic [4:0] INSTR_CYCLE_OSC = 5'h04;
	localparam logic [1:0] RESP_OKAY       = 2'h0;
	localparam logic [1:0] RESP_SLVERR     = 2'h2;
	typedef enum logic [4:0] {
		ST_IDLE    = 5'b00001,
		ST_DELAY   = 5'b00010,
		ST_ACQ     = 5'b00100,
		ST_CONV    = 5'b01000,
		ST_RECOVER = 5'b10000
	} state_t;
	function automatic logic [4:0] acq_periods(input logic [2:0] code);
		case (code)
			3'h1: acq_periods = 5'h02;
			3'h2: acq_periods = 5'h04;
			3'h3: acq_periods = 5'h06;
			3'h4: acq_periods = 5'h08;
			3'h5: acq_periods = 5'h0c;
			3'h6: acq_periods = 5'h10;
			3'h7: acq_periods = 5'h14;
			default: acq_periods = 5'h00;
		endcase
	endfunction : acq_periods
	function automatic logic [6:0] clock_divide(input logic [2:0] code);
		case (code)
			3'h1: clock_divide = 7'h08;
			3'h2: clock_divide = 7'h20;
			3'h4: clock_divide = 7'h04;
			3'h5: clock_divide = 7'h10;
			3'h6: clock_divide = 7'h40;
			default: clock_divide = 7'h02;
		endcase
	endfunction : clock_divide
	function automatic logic is_rc(input logic [2:0] code);
		is_rc = (code[1:0] == 2'h3);
	endfunction : is_rc
endpackage : sar_adc_pkg

// *** bench/sar_adc_control_sequencer_sva.sv ***
// Port-level checker for the converter sequencer.
module sar_adc_control_sequencer_sva (
	input logic        aclk,
	input logic        aresetn,
	input logic        arvalid,
	input logic        arready,
	input logic [31:0] rdata,
	input logic        rvalid,
	input logic        rready,
	input logic        bvalid,
	input logic        portb_analog_default,
	input logic [10:0] pin_analog,
	input logic        sample_enable,
	input logic        conversion_done_flag,
	input logic        converter_enabled
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] low_cnt_r;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Saturates so that a long idle with the sampler shut cannot wrap.
	always_ff @(posedge aclk) begin
		if (!aresetn || sample_enable)
			low_cnt_r <= 8'h00;
		else if (low_cnt_r != 8'hff)
			low_cnt_r <= low_cnt_r + 8'h01;
	end
	sequence s_done;
		$rose(conversion_done_flag);
	endsequence
	sequence s_closed;
		!sample_enable [*4];
	endsequence
	property p_rst_out;
		$rose(aresetn) |-> !converter_enabled && !conversion_done_flag
			&& !bvalid && !rvalid;
	endproperty
	property p_pin_rst;
		$rose(aresetn) |=> pin_analog ==
			($past(portb_analog_default) ? 11'h7ff : 11'h0ff);
	endproperty
	property p_off_idle;
		!converter_enabled [*2] |-> !sample_enable;
	endproperty
	property p_recover;
		s_done |-> s_closed;
	endproperty
	property p_resume;
		s_done and converter_enabled |-> ##[2:200] sample_enable;
	endproperty
	property p_conv_len;
		s_done |-> low_cnt_r >= 8'h16;
	endproperty
	property p_ar_answer;
		arvalid && arready |=> rvalid;
	endproperty
	property p_rdata_hi;
		rvalid |-> rdata[31:8] == 24'h00_0000;
	endproperty
	property p_rhold;
		rvalid && !rready |=> rvalid && $stable(rdata);
	endproperty
	property p_ar_block;
		rvalid |-> !arready;
	endproperty
	a_rst_out: assert property (p_rst_out)
		else $error("outputs not cleared by reset");
	a_pin_rst: assert property (p_pin_rst)
		else $error("pin map after reset wrong");
	a_off_idle: assert property (p_off_idle)
		else $error("sampling while converter off");
	a_recover: assert property (p_recover)
		else $error("sampling resumed too early");
	a_resume: assert property (p_resume)
		else $error("sampling did not resume");
	a_conv_len: assert property (p_conv_len)
		else $error("conversion too short");
	a_rdata_hi: assert property (p_rdata_hi)
		else $error("upper read bits not zero");
	a_rhold: assert property (p_rhold)
		else $error("read data not held");
	a_ar_block: assert property (p_ar_block)
		else $error("read address accepted while busy");
	a_ar_answer: assert property (p_ar_answer)
		else $error("read answer not given after address");
endmodule : sar_adc_control_sequencer_sva

bind sar_adc_control_sequencer sar_adc_control_sequencer_sva u_sva (
	.aclk, .aresetn, .arvalid, .arready, .rdata, .rvalid, .rready, .bvalid,
	.portb_analog_default, .pin_analog, .sample_enable,
	.conversion_done_flag, .converter_enabled);

// *** bench/analog_source_model.sv ***
// Analog sources on the inputs plus the free-running RC converter clock.
module analog_source_model #(
	parameter int RC_PER = 5
) (
	input  logic       aclk,
	input  logic [3:0] analog_channel,
	input  logic [9:0] sar_trial,
	output logic       comparator_high,
	output logic       rc_clock_tick
);
	timeunit 1ns;
	timeprecision 1ns;
	int div_q = 0;
	initial rc_clock_tick = 1'b0;
	function automatic logic [9:0] level(input logic [3:0] ch);
		return {ch, ~ch, 2'b10};
	endfunction : level
	assign comparator_high = (level(analog_channel) >= sar_trial);
	// The RC source keeps running in sleep, unlike the bus clock divider.
	always @(posedge aclk) begin
		div_q <= (div_q == RC_PER - 1) ? 0 : div_q + 1;
		rc_clock_tick <= (div_q == RC_PER - 1);
	end
endmodule : analog_source_model

// *** bench/test_sar_adc_control_sequencer.sv ***
// Self-checking bench for the converter sequencer.
module test_sar_adc_control_sequencer;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] IMPL = 16'h071f;
	localparam int RC_PER = 5;
	localparam logic [7:0] adr_c0 = {sar_adc_pkg::WIX_CTRL0, 2'b00};
	localparam logic [7:0] adr_c1 = {sar_adc_pkg::WIX_CTRL1, 2'b00};
	localparam logic [7:0] adr_c2 = {sar_adc_pkg::WIX_CTRL2, 2'b00};
	localparam logic [7:0] adr_hi = {sar_adc_pkg::WIX_RES_HI, 2'b00};
	localparam logic [7:0] adr_lo = {sar_adc_pkg::WIX_RES_LO, 2'b00};
	localparam logic [7:0] adr_st = {sar_adc_pkg::WIX_STATUS, 2'b00};
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic        awvalid = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0]  wstrb = 4'h0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic [7:0]  araddr = 8'h00;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        portb_analog_default = 1'b0;
	logic        device_sleep = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, resp_q;
	logic [31:0] rdata, rd_q;
	logic [3:0]  analog_channel, strb_q = 4'hf;
	logic        neg_ref_external, pos_ref_external, sample_enable;
	logic [10:0] pin_analog;
	logic [9:0]  sar_trial;
	logic        conversion_done_flag, converter_enabled;
	logic        comparator_high, rc_clock_tick;
	int          err_total = 0;
	int          n_tests = 0;
	int          cyc = 0;
	int          divtab[8] = '{2, 8, 32, 0, 4, 16, 64, 0};
	int          acqtab[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
	sar_adc_control_sequencer #(.IMPL_CHANNELS(IMPL)) DUT (
		.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .portb_analog_default,
		.comparator_high, .rc_clock_tick, .device_sleep, .analog_channel,
		.neg_ref_external, .pos_ref_external, .pin_analog, .sample_enable,
		.sar_trial, .conversion_done_flag, .converter_enabled);
	analog_source_model #(.RC_PER(RC_PER)) u_src (
		.aclk, .analog_channel, .sar_trial, .comparator_high, .rc_clock_tick);
	always #10 aclk = ~aclk;
	always @(posedge aclk) cyc <= cyc + 1;
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask : chk
	task automatic guard(input int k, input int lim);
		if (k > lim) begin
			chk("bounded wait", 1, 0);
			final_report();
		end
	endtask : guard
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h00_0000, d};
		wstrb <= strb_q;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			k++;
			guard(k, 50);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (!(bvalid && bready));
		resp_q = bresp;
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		int k;
		k = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			k++;
			guard(k, 50);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid && !rready)
				rready <= 1'b1;
		end while (!(rvalid && rready));
		rd_q = rdata;
		resp_q = rresp;
		rready <= 1'b0;
	endtask : rd
	task automatic rdc(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		rd(a);
		chk(nm, e, rd_q);
	endtask : rdc
	task automatic wait_done(input int lim);
		int k;
		k = 0;
		while (conversion_done_flag !== 1'b1) begin
			@(posedge aclk);
			k++;
			guard(k, lim);
		end
	endtask : wait_done
	task automatic t_regs();
		rdc("ctrl0 reset", adr_c0, 32'h0000_0000);
		rdc("ctrl1 reset", adr_c1, 32'h0000_0007);
		rdc("ctrl2 reset", adr_c2, 32'h0000_0000);
		chk("pins reset", 32'h0000_00ff, 32'(pin_analog));
		wr(adr_c0, 8'h02);
		rdc("start while off", adr_c0, 32'h0000_0000);
		wr(adr_c1, 8'hff);
		rdc("ctrl1 unused", adr_c1, 32'h0000_003f);
		chk("refs ext", 32'h3, {30'h0, neg_ref_external, pos_ref_external});
		wr(adr_c1, 8'h00);
		rdc("ctrl1 clear", adr_c1, 32'h0000_0000);
		chk("refs int", 32'h0, {30'h0, neg_ref_external, pos_ref_external});
		wr(adr_c2, 8'hff);
		strb_q = 4'h0;
		wr(adr_c2, 8'h00);
		strb_q = 4'hf;
		rdc("ctrl2 unused", adr_c2, 32'h0000_00bf);
		wr(adr_c2, 8'h00);
		wr(adr_c0, 8'hfd);
		rdc("ctrl0 unused", adr_c0, 32'h0000_003d);
		chk("enabled", 1, 32'(converter_enabled));
		chk("channel", 32'hf, 32'(analog_channel));
		wr(adr_c0, 8'h00);
		rdc("ctrl0 off", adr_c0, 32'h0000_0000);
		chk("disabled", 0, 32'(converter_enabled));
		wr(adr_hi, 8'h55);
		chk("result write resp", 0, 32'(resp_q));
		wr(8'h18, 8'h01);
		chk("unmapped write", 2, 32'(resp_q));
		rdc("unmapped data", 8'h18, 32'h0000_0000);
		chk("unmapped read", 2, 32'(resp_q));
		$display("register test done");
	endtask : t_regs
	task automatic t_pins();
		int n;
		for (int c = 0; c < 16; c++) begin
			n = (c < 5) ? 0 : c - 4;
			wr(adr_c1, 8'(c));
			rdc("pin config", adr_c1, 32'(c));
			chk("pin map", 32'h7ff >> n, 32'(pin_analog));
		end
		wr(adr_c1, 8'h00);
		$display("pin map test done");
	endtask : t_pins
	task automatic t_conv(input int i);
		logic [3:0] ch;
		logic [2:0] acq;
		logic [9:0] r;
		int per, lo, t0;
		ch = 4'(i * 2);
		acq = 3'(7 - i);
		per = (divtab[i] == 0) ? RC_PER : divtab[i];
		lo = (acqtab[acq] + 11) * per + ((divtab[i] == 0) ? 4 : 0);
		r = (ch > 10 || !IMPL[ch]) ? 10'h3ff : {ch, ~ch, 2'b10};
		wr(adr_st, 8'h01);
		wr(adr_c2, {i[0], 1'b0, acq, 3'(i)});
		// The start bit is dropped unless the converter is already on.
		wr(adr_c0, {2'b00, ch, 2'b01});
		if (acq == 3'h0)
			repeat (20) @(posedge aclk);
		device_sleep <= (divtab[i] == 0);
		wr(adr_c0, {2'b00, ch, 2'b11});
		t0 = cyc;
		rdc("busy", adr_c0, {26'h0, ch, 2'b11});
		wait_done(3000);
		chk("conv time", 1, 32'(cyc - t0 >= lo - per && cyc - t0 <= lo + 2 * per + 16));
		device_sleep <= 1'b0;
		rdc("go cleared", adr_c0, {26'h0, ch, 2'b01});
		rdc("result high", adr_hi, i[0] ? 32'(r[9:8]) : 32'(r[9:2]));
		rdc("result low", adr_lo, i[0] ? 32'(r[7:0]) : 32'({r[1:0], 6'h0}));
		rdc("done flag", adr_st, 32'h0000_0001);
		repeat (2 * per + 4) @(posedge aclk);
		$display("conversion test %0d done", i);
	endtask : t_conv
	task automatic t_sleep();
		wr(adr_st, 8'h01);
		wr(adr_c2, 8'h00);
		wr(adr_c0, 8'h05);
		repeat (20) @(posedge aclk);
		device_sleep <= 1'b1;
		wr(adr_c0, 8'h07);
		repeat (100) @(posedge aclk);
		chk("stalled in sleep", 0, 32'(conversion_done_flag));
		device_sleep <= 1'b0;
		wait_done(200);
		rdc("result after wake", adr_hi, 32'h0000_001e);
		$display("sleep test done");
	endtask : t_sleep
	task automatic t_abort();
		logic [31:0] hi;
		wr(adr_st, 8'h01);
		rd(adr_hi);
		hi = rd_q;
		wr(adr_c2, 8'h06);
		wr(adr_c0, 8'h09);
		repeat (20) @(posedge aclk);
		wr(adr_c0, 8'h0b);
		repeat (50) @(posedge aclk);
		portb_analog_default <= 1'b1;
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (900) @(posedge aclk);
		chk("no flag after abort", 0, 32'(conversion_done_flag));
		chk("off after reset", 0, 32'(converter_enabled));
		chk("pins strap set", 32'h7ff, 32'(pin_analog));
		rdc("ctrl0 after reset", adr_c0, 32'h0000_0000);
		rdc("ctrl1 strap set", adr_c1, 32'h0000_0000);
		rdc("result kept", adr_hi, hi);
		$display("reset abort test done");
	endtask : t_abort
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_pins();
		for (int i = 0; i < 8; i++)
			t_conv(i);
		t_sleep();
		t_abort();
		final_report();
	end
endmodule : test_sar_adc_control_sequencer
